// file: logic/atc_pkg.sv
// Purpose: constants, register layout and types of the auxiliary 16-bit timer
// Assumes: 32-bit classic wishbone, one byte register per aligned word
// Notes:   register indices are word indices, byte address is four times index
`default_nettype none

package atc_pkg;

  // ---------------------------------------------------------------------------
  // register map (word indices)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL  = 8'hc8;
  localparam logic [7:0] IDX_MODE     = 8'hc9;
  localparam logic [7:0] IDX_CAP_LOW  = 8'hca;
  localparam logic [7:0] IDX_CAP_HIGH = 8'hcb;
  localparam logic [7:0] IDX_CNT_LOW  = 8'hcc;
  localparam logic [7:0] IDX_CNT_HIGH = 8'hcd;
  localparam int unsigned ADR_LSB     = 2;

  // ---------------------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  MODE_WR_MASK  = 8'h29;
  localparam logic [7:0]  CAP_RESET     = 8'h00;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [23:0] READ_PAD      = 24'h000000;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [15:0] COUNT_ONES    = 16'hffff;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;

  // ---------------------------------------------------------------------------
  // timing: clocks per count tick
  // ---------------------------------------------------------------------------
  localparam int unsigned BAUD_DIV      = 2;
  localparam int unsigned TICK_DIV_SLOW = 12;
  localparam int unsigned TICK_DIV_FAST = 4;
  localparam int unsigned PRESC_W       = 4;
  localparam int unsigned SERIAL_VAR_BIT = 0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic external_edge_flag;
    logic rx_baud_source_sel;
    logic tx_baud_source_sel;
    logic trigger_pin_enable;
    logic run_control;
    logic counter_timer_select;
    logic capture_reload_select;
  } atc_ctrl_s;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       tick_speed_select;
    logic       rsvd_mid;
    logic       capture_auto_clear;
    logic [1:0] rsvd_lo;
    logic       down_count_enable;
  } atc_mode_s;

  typedef struct packed {
    logic external_count_pin;
    logic trigger_pin;
  } atc_pins_s;

  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } atc_ticks_s;

  typedef enum logic [3:0] {
    OP_CAPTURE = 4'h1,
    OP_RELOAD  = 4'h2,
    OP_UPDOWN  = 4'h4,
    OP_BAUD    = 4'h8
  } atc_op_e;

endpackage

`default_nettype wire

// file: logic/atc_timer.sv
// Purpose: auxiliary 16-bit timer with capture, auto-reload, up/down and baud generation
// Assumes: pins synchronous-sampled at clk_i, registers over classic wishbone
// Notes:   outputs are registered; ack follows a request by one clock
`timescale 1ns/1ps
`default_nettype none

module atc_timer #(
  parameter int unsigned ADR_W         = 10,
  parameter int unsigned TICK_DIV_SLOW = atc_pkg::TICK_DIV_SLOW,
  parameter int unsigned TICK_DIV_FAST = atc_pkg::TICK_DIV_FAST
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // pins
  input  wire atc_pkg::atc_pins_s pins_i,
  // serial port and interrupt controller
  input  wire logic               t1_overflow_i,
  input  wire logic [1:0]         serial_mode_i,
  input  wire logic               irq_enable_i,
  output atc_pkg::atc_ticks_s     baud_ticks_o,
  output logic                    irq_o
);

  // ---------------------------------------------------------------------------
  // constants local to the counter
  // ---------------------------------------------------------------------------
  localparam int unsigned PW = atc_pkg::PRESC_W;
  localparam logic [PW-1:0] BAUD_LAST = PW'(atc_pkg::BAUD_DIV - 1);
  localparam logic [PW-1:0] SLOW_LAST = PW'(TICK_DIV_SLOW - 1);
  localparam logic [PW-1:0] FAST_LAST = PW'(TICK_DIV_FAST - 1);
  localparam logic [PW-1:0] PRESC_ZERO = '0;
  localparam logic [PW-1:0] PRESC_ONE  = PW'(1);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  atc_pkg::atc_ctrl_s ctrl_ff;
  atc_pkg::atc_ctrl_s nxt_ctrl;
  atc_pkg::atc_mode_s mode_ff;
  logic [15:0]        count_ff;
  logic [15:0]        nxt_count;
  logic [15:0]        cap_ff;
  logic [15:0]        nxt_cap;
  logic [PW-1:0]      presc_ff;
  logic [2:0]         cnt_sync_ff;
  logic [2:0]         trg_sync_ff;
  logic               ack_ff;
  logic [31:0]        dat_ff;
  logic               irq_ff;
  atc_pkg::atc_ticks_s ticks_ff;

  // ---------------------------------------------------------------------------
  // decode of the operating mode
  // ---------------------------------------------------------------------------
  function automatic atc_pkg::atc_op_e op_of(input atc_pkg::atc_ctrl_s c, input atc_pkg::atc_mode_s m);
    if (c.rx_baud_source_sel || c.tx_baud_source_sel) begin
      op_of = atc_pkg::OP_BAUD;
    end else if (c.capture_reload_select) begin
      op_of = atc_pkg::OP_CAPTURE;
    end else if (m.down_count_enable) begin
      op_of = atc_pkg::OP_UPDOWN;
    end else begin
      op_of = atc_pkg::OP_RELOAD;
    end
  endfunction

  // index match on the word address
  function automatic logic idx_is(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    idx_is = (adr[atc_pkg::ADR_LSB +: 8] == idx);
  endfunction

  atc_pkg::atc_op_e op;
  assign op = op_of(ctrl_ff, mode_ff);

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic       req_new;
  logic       wr_go;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_cap_lo;
  logic       wr_cap_hi;
  logic       wr_cnt_lo;
  logic       wr_cnt_hi;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  // a request is answered one clock later; writes commit at the ack edge
  assign req_new   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_go     = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
  assign wbyte     = wb_dat_i[7:0];
  assign wr_ctrl   = wr_go & idx_is(wb_adr_i, atc_pkg::IDX_CONTROL);
  assign wr_mode   = wr_go & idx_is(wb_adr_i, atc_pkg::IDX_MODE);
  assign wr_cap_lo = wr_go & idx_is(wb_adr_i, atc_pkg::IDX_CAP_LOW);
  assign wr_cap_hi = wr_go & idx_is(wb_adr_i, atc_pkg::IDX_CAP_HIGH);
  assign wr_cnt_lo = wr_go & idx_is(wb_adr_i, atc_pkg::IDX_CNT_LOW);
  assign wr_cnt_hi = wr_go & idx_is(wb_adr_i, atc_pkg::IDX_CNT_HIGH);

  // read selection; unmapped indices read zero
  assign rd_byte = idx_is(wb_adr_i, atc_pkg::IDX_CONTROL)  ? ctrl_ff :
                   idx_is(wb_adr_i, atc_pkg::IDX_MODE)     ? mode_ff :
                   idx_is(wb_adr_i, atc_pkg::IDX_CAP_LOW)  ? cap_ff[7:0] :
                   idx_is(wb_adr_i, atc_pkg::IDX_CAP_HIGH) ? cap_ff[15:8] :
                   idx_is(wb_adr_i, atc_pkg::IDX_CNT_LOW)  ? count_ff[7:0] :
                   idx_is(wb_adr_i, atc_pkg::IDX_CNT_HIGH) ? count_ff[15:8] :
                   atc_pkg::BYTE_ZERO;

  // ---------------------------------------------------------------------------
  // pin sampling and edge detection
  // ---------------------------------------------------------------------------
  logic cnt_fall;
  logic trg_fall;
  logic trg_level;

  // stage 0 feeds only stage 1; edges compare stages 1 and 2
  assign cnt_fall  = cnt_sync_ff[2] & ~cnt_sync_ff[1];
  assign trg_fall  = trg_sync_ff[2] & ~trg_sync_ff[1];
  assign trg_level = trg_sync_ff[1];

  // ---------------------------------------------------------------------------
  // tick generation
  // ---------------------------------------------------------------------------
  logic          baud_mode;
  logic [PW-1:0] presc_last;
  logic          presc_hit;
  logic [PW-1:0] nxt_presc;
  logic          tick;

  assign baud_mode  = (op == atc_pkg::OP_BAUD);
  // baud generation overrides the timer rate and the counter select
  assign presc_last = baud_mode ? BAUD_LAST :
                      (mode_ff.tick_speed_select ? FAST_LAST : SLOW_LAST);
  assign presc_hit  = (presc_ff >= presc_last);
  assign nxt_presc  = presc_hit ? PRESC_ZERO : presc_ff + PRESC_ONE;
  // run control gates every count source
  assign tick = ctrl_ff.run_control &
                ((baud_mode || !ctrl_ff.counter_timer_select) ? presc_hit : cnt_fall);

  // ---------------------------------------------------------------------------
  // count events
  // ---------------------------------------------------------------------------
  logic        at_ones;
  logic        count_up;
  logic        up_ovf;
  logic        down_match;
  logic        edge_act;
  logic        edge_cr;
  logic        tf_set;
  logic        exf_set;
  logic        exf_toggle;
  logic        t2_ovf;
  logic [15:0] count_inc;
  logic [15:0] count_dec;

  assign at_ones    = (count_ff == atc_pkg::COUNT_ONES);
  // in up/down mode the trigger pin level chooses the direction
  assign count_up   = (op != atc_pkg::OP_UPDOWN) | trg_level;
  assign up_ovf     = tick & count_up & at_ones;
  assign down_match = tick & ~count_up & (count_ff == cap_ff);
  assign count_inc  = count_ff + atc_pkg::COUNT_ONE;
  assign count_dec  = count_ff - atc_pkg::COUNT_ONE;
  // enabled trigger edge; capture or reload only outside baud mode
  assign edge_act   = trg_fall & ctrl_ff.trigger_pin_enable;
  assign edge_cr    = edge_act & ~baud_mode;
  // overflow flag never set while generating baud clocks
  assign tf_set     = (up_ovf | down_match) & ~baud_mode;
  assign exf_set    = edge_act & (op != atc_pkg::OP_UPDOWN);
  assign exf_toggle = (up_ovf | down_match) & (op == atc_pkg::OP_UPDOWN);
  assign t2_ovf     = up_ovf & baud_mode;

  // ---------------------------------------------------------------------------
  // next count and capture value
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    nxt_cap   = cap_ff;
    unique case (op)
      atc_pkg::OP_BAUD: begin
        if (up_ovf) begin
          nxt_count = cap_ff;
        end else if (tick) begin
          nxt_count = count_inc;
        end
      end
      atc_pkg::OP_CAPTURE: begin
        if (tick) begin
          nxt_count = count_inc;
        end
        if (edge_cr) begin
          nxt_cap = count_ff;
          if (mode_ff.capture_auto_clear) begin
            nxt_count = atc_pkg::COUNT_ZERO;
          end
        end
      end
      atc_pkg::OP_RELOAD: begin
        if (up_ovf || edge_cr) begin
          nxt_count = cap_ff;
        end else if (tick) begin
          nxt_count = count_inc;
        end
      end
      atc_pkg::OP_UPDOWN: begin
        if (up_ovf) begin
          nxt_count = cap_ff;
        end else if (down_match) begin
          nxt_count = atc_pkg::COUNT_ONES;
        end else if (tick) begin
          nxt_count = count_up ? count_inc : count_dec;
        end
      end
    endcase
    // software writes to the count bytes take precedence
    if (wr_cnt_lo) begin
      nxt_count[7:0] = wbyte;
    end
    if (wr_cnt_hi) begin
      nxt_count[15:8] = wbyte;
    end
    // a capture in the same cycle wins over a software write
    if (wr_cap_lo && !edge_cr) begin
      nxt_cap[7:0] = wbyte;
    end
    if (wr_cap_hi && !edge_cr) begin
      nxt_cap[15:8] = wbyte;
    end
    if (wr_cap_lo && edge_cr && (op != atc_pkg::OP_CAPTURE)) begin
      nxt_cap[7:0] = wbyte;
    end
    if (wr_cap_hi && edge_cr && (op != atc_pkg::OP_CAPTURE)) begin
      nxt_cap[15:8] = wbyte;
    end
  end

  // ---------------------------------------------------------------------------
  // control register update; hardware sets win over software clears
  // ---------------------------------------------------------------------------
  atc_pkg::atc_ctrl_s sw_ctrl;
  assign sw_ctrl = wr_ctrl ? atc_pkg::atc_ctrl_s'(wbyte) : ctrl_ff;

  always_comb begin
    nxt_ctrl = sw_ctrl;
    // only software lowers the overflow flag; it may also raise it
    nxt_ctrl.overflow_flag = sw_ctrl.overflow_flag | tf_set;
    if (exf_set) begin
      nxt_ctrl.external_edge_flag = 1'b1;
    end else if (exf_toggle) begin
      nxt_ctrl.external_edge_flag = ~sw_ctrl.external_edge_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // serial time base and interrupt request
  // ---------------------------------------------------------------------------
  logic serial_var;
  logic irq_req;
  atc_pkg::atc_ticks_s nxt_ticks;

  assign serial_var = serial_mode_i[atc_pkg::SERIAL_VAR_BIT];
  // variable-rate serial modes take their time base per direction
  assign nxt_ticks.rx_tick = serial_var & (ctrl_ff.rx_baud_source_sel ? t2_ovf : t1_overflow_i);
  assign nxt_ticks.tx_tick = serial_var & (ctrl_ff.tx_baud_source_sel ? t2_ovf : t1_overflow_i);
  // toggled external flag in up/down mode does not interrupt
  assign irq_req = irq_enable_i &
                   (ctrl_ff.overflow_flag |
                    (ctrl_ff.external_edge_flag & (op != atc_pkg::OP_UPDOWN)));

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_sync_ff <= 3'h7;
      trg_sync_ff <= 3'h7;
    end else begin
      cnt_sync_ff <= {cnt_sync_ff[1:0], pins_i.external_count_pin};
      trg_sync_ff <= {trg_sync_ff[1:0], pins_i.trigger_pin};
    end
  end

  // ---------------------------------------------------------------------------
  // timer registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff  <= atc_pkg::CONTROL_RESET;
      mode_ff  <= atc_pkg::MODE_RESET;
      count_ff <= atc_pkg::COUNT_ZERO;
      cap_ff   <= {atc_pkg::CAP_RESET, atc_pkg::CAP_RESET};
      presc_ff <= PRESC_ZERO;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      count_ff <= nxt_count;
      cap_ff   <= nxt_cap;
      presc_ff <= nxt_presc;
      if (wr_mode) begin
        mode_ff <= wbyte & atc_pkg::MODE_WR_MASK; // reserved bits stay zero
      end
    end
  end

  // ---------------------------------------------------------------------------
  // bus answer and registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      dat_ff   <= {atc_pkg::READ_PAD, atc_pkg::BYTE_ZERO};
      irq_ff   <= 1'b0;
      ticks_ff <= '0;
    end else begin
      ack_ff   <= req_new;
      irq_ff   <= irq_req;
      ticks_ff <= nxt_ticks;
      if (req_new) begin
        dat_ff <= {atc_pkg::READ_PAD, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------------------
  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = dat_ff;
  assign irq_o        = irq_ff;
  assign baud_ticks_o = ticks_ff;

endmodule // atc_timer

`default_nettype wire

// file: bench/atc_timer_props.sv
// Purpose: port-level checks of the auxiliary timer
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every atc_timer instance
`timescale 1ns/1ps
`default_nettype none
module atc_timer_props #(
  parameter int unsigned ADR_W = 10
) (
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // wishbone
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [ADR_W-1:0]    wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  // pins, serial port, interrupt
  input wire atc_pkg::atc_pins_s  pins_i,
  input wire logic                t1_overflow_i,
  input wire logic [1:0]          serial_mode_i,
  input wire logic                irq_enable_i,
  input wire atc_pkg::atc_ticks_s baud_ticks_o,
  input wire logic                irq_o
);
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_pad_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_dat_holds: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data changed without request");
  a_irq_gated: assert property (!irq_enable_i |=> !irq_o)
    else $error("interrupt while disabled");
  a_tick_serial_gate: assert property (!serial_mode_i[0] ##1 !serial_mode_i[0] |=> baud_ticks_o == 2'b00)
    else $error("baud tick outside modes 1 and 3");
  a_tx_tick_pulse: assert property (baud_ticks_o.tx_tick |=> !baud_ticks_o.tx_tick)
    else $error("transmit tick longer than one cycle");
  a_rx_tick_pulse: assert property (baud_ticks_o.rx_tick |=> !baud_ticks_o.rx_tick)
    else $error("receive tick longer than one cycle");
  // main scenarios seen
  c_irq: cover property (irq_o);
  c_tx_tick: cover property (baud_ticks_o.tx_tick);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // atc_timer_props
bind atc_timer atc_timer_props #(.ADR_W(ADR_W)) u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i), .t1_overflow_i(t1_overflow_i),
  .serial_mode_i(serial_mode_i), .irq_enable_i(irq_enable_i), .baud_ticks_o(baud_ticks_o), .irq_o(irq_o));
`default_nettype wire

// file: bench/atc_pin_model.sv
// Purpose: far side of the timer: trigger pin, count pin, timer 1 overflow
// Assumes: pins idle high, a request gives one falling edge
// Notes:   low phases last four clocks so the synchroniser sees them
`timescale 1ns/1ps
`default_nettype none
module atc_pin_model (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // requests from the bench
  input  wire logic          trig_req_i,
  input  wire logic          cnt_req_i,
  input  wire logic          t1_en_i,
  // towards the timer
  output atc_pkg::atc_pins_s pins_o,
  output logic               t1_ovf_o
);
  // ---------------------------------------------------------------------------
  // pin timing
  // ---------------------------------------------------------------------------
  logic [2:0] trig_ff;
  logic [2:0] cnt_ff;
  logic [3:0] t1_ff;
  // low-phase counters and timer 1 overflow divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_ff <= 3'h0;
      cnt_ff  <= 3'h0;
      t1_ff   <= 4'h0;
    end else begin
      trig_ff <= trig_req_i ? 3'h4 : (trig_ff != 3'h0 ? trig_ff - 3'h1 : 3'h0);
      cnt_ff  <= cnt_req_i ? 3'h4 : (cnt_ff != 3'h0 ? cnt_ff - 3'h1 : 3'h0);
      t1_ff   <= t1_en_i ? t1_ff + 4'h1 : 4'h0;
    end
  end
  // levels held long enough for edge detection
  assign pins_o.trigger_pin        = (trig_ff == 3'h0);
  assign pins_o.external_count_pin = (cnt_ff == 3'h0);
  assign t1_ovf_o                  = t1_en_i && (t1_ff[2:0] == 3'h7);
endmodule // atc_pin_model
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench of the auxiliary timer
// Assumes: one-cycle wishbone answer, short tick dividers
// Notes:   register rows first, then reset and mode scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic                clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic                trig = 1'b0, cnt = 1'b0, t1_en = 1'b0, irq_en = 1'b1, ack, irq, t1_ovf;
  logic [1:0]          smode = 2'h0;
  logic [9:0]          adr = 10'h000;
  logic [31:0]         wdat = 32'h00000000, rdat;
  logic [7:0]          q, q2;
  atc_pkg::atc_pins_s  pins;
  atc_pkg::atc_ticks_s ticks;
  int                  error_cnt = 0, compares = 0, cyc_n = 0, tx_n = 0, rx_n = 0, t1_n = 0, a, b, t;
  logic [23:0]         rows [6] = '{24'hca5a5a, 24'hcba5a5, 24'hc9ff29, 24'hffff00, 24'hcc3c3c, 24'hc80000};
  atc_timer #(.TICK_DIV_SLOW(3), .TICK_DIV_FAST(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pins_i(pins), .t1_overflow_i(t1_ovf), .serial_mode_i(smode), .irq_enable_i(irq_en),
    .baud_ticks_o(ticks), .irq_o(irq));
  atc_pin_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .trig_req_i(trig), .cnt_req_i(cnt), .t1_en_i(t1_en),
    .pins_o(pins), .t1_ovf_o(t1_ovf));
  // clock
  initial forever #4 clk_i = ~clk_i;
  // tick and pulse counters, sampled where outputs are settled
  always @(negedge clk_i) begin
    tx_n += (ticks.tx_tick === 1'b1);
    rx_n += (ticks.rx_tick === 1'b1);
    t1_n += (t1_ovf === 1'b1);
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'h0}; wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  // one falling edge on the trigger pin or the count pin
  task automatic pulse(input bit tr);
    @(posedge clk_i);
    if (tr) trig <= 1'b1; else cnt <= 1'b1;
    @(posedge clk_i);
    if (tr) trig <= 1'b0; else cnt <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[k]) begin
      wb(1'b1, rows[k][23:16], rows[k][15:8], q);
      wb(1'b0, rows[k][23:16], 8'h00, q);
      `CHK("row", rows[k][7:0], q)
    end
    $display("test rows done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (t = 8'hc8; t <= 8'hcd; t++) begin
      wb(1'b0, t[7:0], 8'h00, q);
      `CHK("reset value", 8'h00, q)
    end
    $display("test reset done");
    wb(1'b1, 8'hc9, 8'h08, q); wb(1'b1, 8'hcc, 8'h34, q); wb(1'b1, 8'hcd, 8'h12, q);
    wb(1'b1, 8'hc8, 8'h09, q); pulse(1'b1);
    wb(1'b0, 8'hca, 8'h00, q); `CHK("capture low", 8'h34, q)
    wb(1'b0, 8'hcb, 8'h00, q); `CHK("capture high", 8'h12, q)
    wb(1'b0, 8'hcc, 8'h00, q); wb(1'b0, 8'hcd, 8'h00, q2);
    `CHK("cleared count", 16'h0000, {q2, q})
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("edge flag", 8'h49, q)
    `CHK("irq edge", 1'b1, irq)
    wb(1'b1, 8'hc8, 8'h01, q); wb(1'b1, 8'hcc, 8'h21, q); pulse(1'b1);
    wb(1'b0, 8'hca, 8'h00, q); `CHK("ignored trigger", 8'h34, q)
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("no edge flag", 8'h01, q)
    $display("test capture done");
    wb(1'b1, 8'hc9, 8'h00, q); wb(1'b1, 8'hc8, 8'h08, q); wb(1'b1, 8'hcc, 8'h00, q); pulse(1'b1);
    wb(1'b0, 8'hcc, 8'h00, q); wb(1'b0, 8'hcd, 8'h00, q2);
    `CHK("reload", 16'h1234, {q2, q})
    $display("test reload done");
    wb(1'b1, 8'hc8, 8'h00, q); wb(1'b1, 8'hcc, 8'hff, q); wb(1'b1, 8'hcd, 8'hff, q);
    wb(1'b1, 8'hc8, 8'h07, q); pulse(1'b0);
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("overflow flag", 8'h87, q)
    `CHK("irq overflow", 1'b1, irq)
    wb(1'b0, 8'hcc, 8'h00, q); `CHK("wrapped", 8'h00, q)
    repeat (20) @(posedge clk_i);
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("flag kept", 8'h87, q)
    wb(1'b1, 8'hc8, 8'h03, q); wb(1'b0, 8'hc8, 8'h00, q); `CHK("flag cleared", 8'h03, q)
    `CHK("irq cleared", 1'b0, irq)
    pulse(1'b0); wb(1'b0, 8'hcc, 8'h00, q); `CHK("stopped counter", 8'h00, q)
    wb(1'b1, 8'hc8, 8'h07, q); pulse(1'b0); pulse(1'b0); pulse(1'b0);
    wb(1'b0, 8'hcc, 8'h00, q); `CHK("edge count", 8'h03, q)
    $display("test counter done");
    wb(1'b1, 8'hc8, 8'h04, q); repeat (40) @(posedge clk_i); wb(1'b1, 8'hc8, 8'h00, q);
    wb(1'b0, 8'hcc, 8'h00, q); repeat (20) @(posedge clk_i); wb(1'b0, 8'hcc, 8'h00, q2);
    `CHK("timer ran", 1'b1, q > 8'h03)
    `CHK("held count", q, q2)
    wb(1'b1, 8'hc9, 8'h20, q); wb(1'b1, 8'hcc, 8'h00, q); wb(1'b1, 8'hc8, 8'h04, q);
    repeat (40) @(posedge clk_i); wb(1'b1, 8'hc8, 8'h00, q); wb(1'b0, 8'hcc, 8'h00, q);
    `CHK("fast ticks", 1'b1, q >= 8'h14 && q <= 8'h16)
    $display("test timer done");
    wb(1'b1, 8'hca, 8'hf0, q); wb(1'b1, 8'hcb, 8'hff, q); wb(1'b1, 8'hcc, 8'hf0, q); wb(1'b1, 8'hcd, 8'hff, q);
    smode <= 2'h1; wb(1'b1, 8'hc8, 8'h34, q); repeat (8) @(posedge clk_i);
    a = rx_n; b = tx_n; repeat (64) @(posedge clk_i);
    `CHK("rx ticks", 2, rx_n - a)
    `CHK("tx ticks", 2, tx_n - b)
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("no flag in baud", 8'h34, q)
    wb(1'b1, 8'hc8, 8'h24, q); repeat (8) @(posedge clk_i);
    a = t1_n; b = tx_n; t1_en <= 1'b1; repeat (40) @(posedge clk_i); t1_en <= 1'b0; repeat (10) @(posedge clk_i);
    `CHK("t1 pulses", 1'b1, t1_n - a > 0)
    `CHK("tx from t1", t1_n - a, tx_n - b)
    $display("test baud done");
    wb(1'b1, 8'hc8, 8'h00, q); wb(1'b1, 8'hc9, 8'h01, q); wb(1'b1, 8'hca, 8'h05, q); wb(1'b1, 8'hcb, 8'h00, q);
    wb(1'b1, 8'hcc, 8'h06, q); wb(1'b1, 8'hcd, 8'h00, q); trig <= 1'b1; wb(1'b1, 8'hc8, 8'h06, q);
    pulse(1'b0); pulse(1'b0); wb(1'b0, 8'hcc, 8'h00, q); wb(1'b0, 8'hcd, 8'h00, q2);
    `CHK("down match", 16'hffff, {q2, q})
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("down flags", 8'hc6, q)
    trig <= 1'b0; repeat (8) @(posedge clk_i); pulse(1'b0);
    wb(1'b0, 8'hcc, 8'h00, q); `CHK("up reload", 8'h05, q)
    wb(1'b0, 8'hc8, 8'h00, q); `CHK("edge flag toggled", 8'h86, q)
    $display("test updown done");
    smode <= 2'h0; irq_en <= 1'b0; repeat (4) @(posedge clk_i);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
